// [src/rsl_pkg.sv]
// Constants, states and timing for the redundant serial station link.
package rsl_pkg;
  // ==========================================================
  // Control byte values
  localparam logic [7:0] RSL_UNUSED_BYTE = 8'hFA;
  localparam logic [7:0] RSL_INVERT_PREFIX = 8'hFB;
  localparam logic [7:0] RSL_START_BYTE = 8'hFC;
  localparam logic [7:0] RSL_ARB_BYTE = 8'hFD;
  localparam logic [7:0] RSL_ABORT_BYTE = 8'hFE;
  localparam logic [7:0] RSL_CLOSE_BYTE = 8'hFF;
  // ==========================================================
  // Addresses and packet type
  localparam logic [7:0] RSL_MANAGER_ADDR = 8'hE0;
  localparam logic [7:0] RSL_TYPE_EMBEDDED = 8'hF5; // RULE9
  localparam logic [7:0] RSL_BLADE_MSG_ADDR = 8'h20; // RULE10
  localparam logic [7:0] RSL_MANAGER_MSG_ADDR = 8'h41; // RULE10
  // ==========================================================
  // Timing, in microseconds, and derived cycle counts
  localparam int RSL_CLK_HZ = 25000000;
  localparam int RSL_BAUD = 57600;
  localparam int RSL_BIT_CYCLES = RSL_CLK_HZ / RSL_BAUD;
  localparam int RSL_STARTUP_US = 500000;
  localparam int RSL_RECEIVE_US = 2000000;
  localparam int RSL_ARB_SLOT_US = 500;
  localparam int RSL_BACKOFF_MIN_US = 3000;
  localparam int RSL_GAP_US = 50;
  localparam int RSL_STARTUP_CYC = RSL_STARTUP_US * (RSL_CLK_HZ / 1000000);
  localparam int RSL_RECEIVE_CYC = RSL_RECEIVE_US * (RSL_CLK_HZ / 1000000);
  localparam int RSL_ARB_SLOT_CYC = RSL_ARB_SLOT_US * (RSL_CLK_HZ / 1000000);
  localparam int RSL_BACKOFF_MIN_CYC = RSL_BACKOFF_MIN_US * (RSL_CLK_HZ / 1000000);
  localparam int RSL_GAP_CYC = RSL_GAP_US * (RSL_CLK_HZ / 1000000);
  localparam int RSL_ARB_COUNT = 8;
  localparam int RSL_SEND_ATTEMPTS = 10;
  localparam int RSL_MAX_LEN = 1028;
  // ==========================================================
  // Station states
  typedef enum logic [2:0] {
    RSL_ST_DETACHED, RSL_ST_STARTUP, RSL_ST_IDLE, RSL_ST_RECEIVE,
    RSL_ST_ARB, RSL_ST_BACKOFF, RSL_ST_SEND, RSL_ST_ABORT
  } rsl_state_type;
endpackage : rsl_pkg

// [src/rsl_fifo.sv]
// Small valid/ready FIFO for outgoing packet bytes.
`timescale 1ns/1ns
module rsl_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  logic ready_q;
  // Pointers wrap by overflow, so only power-of-two depths work
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two");
  end
  // Ready is a flop so the upstream port comes straight from a register
  assign in_ready = ready_q;
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready && ce;
  assign pop = out_valid && out_ready && ce;
  // ==========================================================
  // Storage and pointers; full and empty come from the count
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop) rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      ready_q <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH);
    end
  end
endmodule : rsl_fifo

// [src/rsl_station.sv]
// Station logic for the redundant shared serial management link.
// What this block does
// [RULE1] Select pair 01 picks A, 10 picks B
// [RULE2] Isolate alone detaches from the bus
// [RULE3] Isolate plus restart detaches and resets controller
// [RULE4] Pins active low; restart alone does nothing
// [RULE5] Use isolate/restart pair of selected link
// [RULE6] Control bytes FA to FF as defined
// [RULE7] Send control-valued bytes as prefix plus complement
// [RULE8] Complement byte after prefix before storing
// [RULE9] Embedded message packets carry type F5h
// [RULE10] Message addresses 20h blade, 41h manager
// [RULE11] Echo mismatch or framing error is collision
// [RULE12] Solicited arbitrates at once; unsolicited backs off
// [RULE13] Startup: watch bus, 500 ms timeout
// [RULE14] Receive from start until close, abort, timeout
// [RULE15] Discard bad, misaddressed or malformed packets
// [RULE16] Win after eight clean arbitration bytes
// [RULE17] Each arbitration byte done within 500 us
// [RULE18] Random 1 to 8 slot delay before each
// [RULE19] Backoff after collision; restart on other traffic
// [RULE20] Backoff is 3 ms plus 0-31 slots
// [RULE21] Winner sends start, body, close; ten attempts
// [RULE22] At least 50 us between packet bytes
// [RULE23] Release driver soon after last byte
// [RULE24] 57600 baud, 8 data bits, no parity
// [RULE25] Accept only from and send only to E0h
// [RULE26] Minimum inter-byte gap 50 us
// [RULE27] Checksum is zero minus 16-bit byte sum
// [RULE28] Random counts from slot-seeded LFSR
`timescale 1ns/1ns
module rsl_station #(
  parameter int STARTUP_CYC = rsl_pkg::RSL_STARTUP_CYC,
  parameter int RECEIVE_CYC = rsl_pkg::RSL_RECEIVE_CYC,
  parameter int BACKOFF_MIN_CYC = rsl_pkg::RSL_BACKOFF_MIN_CYC,
  parameter int ARB_SLOT_CYC = rsl_pkg::RSL_ARB_SLOT_CYC,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] slot_addr,
  input wire logic select_a,
  input wire logic select_b,
  input wire logic link_isolate_a_n,
  input wire logic link_isolate_b_n,
  input wire logic controller_restart_a_n,
  input wire logic controller_restart_b_n,
  input wire logic rx_a,
  input wire logic rx_b,
  output logic tx_a,
  output logic tx_b,
  output logic tx_en_a,
  output logic tx_en_b,
  output logic blade_controller_reset,
  input wire logic [7:0] send_data,
  input wire logic send_last,
  input wire logic send_valid,
  output logic send_ready,
  input wire logic send_solicited,
  output logic send_done,
  output logic send_failed,
  output logic [7:0] recv_data,
  output logic recv_valid,
  output logic recv_good,
  output logic recv_bad
);
  import rsl_pkg::*;
  if (STARTUP_CYC < 1 || RECEIVE_CYC < 1 || BACKOFF_MIN_CYC < 1 || ARB_SLOT_CYC < 1) begin : g_bad_timing
    $error("timing counts must be at least one cycle");
  end
  // ==========================================================
  // Reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_ok;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_ok = rst_sync_q[1];
  // ==========================================================
  // Link selection and isolation (pins already synchronous)
  logic sel_a;
  logic sel_b;
  logic iso_n;
  logic rst_pin_n;
  logic attached;
  assign sel_a = select_a && !select_b; // RULE1
  assign sel_b = select_b && !select_a; // RULE1
  assign iso_n = sel_b ? link_isolate_b_n : link_isolate_a_n; // RULE5
  assign rst_pin_n = sel_b ? controller_restart_b_n : controller_restart_a_n; // RULE5
  // Restart alone is ignored; isolate decides attachment
  assign attached = (sel_a || sel_b) && iso_n; // RULE2 RULE4
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) blade_controller_reset <= 1'b0;
    else if (clk_en) blade_controller_reset <= (sel_a || sel_b) && !iso_n && !rst_pin_n; // RULE3
  end
  logic rx_line;
  assign rx_line = sel_b ? rx_b : (sel_a ? rx_a : 1'b1);
  // ==========================================================
  // UART receiver, 8N1 at 57600
  logic [15:0] rbit_q;
  logic [3:0] ridx_q;
  logic [7:0] rshift_q;
  logic rbusy_q;
  logic rx_ev_q;
  logic rx_ferr_q;
  logic [7:0] rx_byte_q;
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      rbit_q <= 16'h0000;
      ridx_q <= 4'h0;
      rshift_q <= 8'h00;
      rbusy_q <= 1'b0;
      rx_ev_q <= 1'b0;
      rx_ferr_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else if (clk_en) begin
      rx_ev_q <= 1'b0;
      if (!attached) begin
        rbusy_q <= 1'b0; // RULE2
      end else if (!rbusy_q) begin
        if (!rx_line) begin
          rbusy_q <= 1'b1;
          rbit_q <= 16'(RSL_BIT_CYCLES / 2);
          ridx_q <= 4'h0;
        end
      end else if (rbit_q != 16'h0000) begin
        rbit_q <= rbit_q - 16'h0001;
      end else begin
        rbit_q <= 16'(RSL_BIT_CYCLES - 1);
        ridx_q <= ridx_q + 4'h1;
        if (ridx_q >= 4'h1 && ridx_q <= 4'h8) rshift_q <= {rx_line, rshift_q[7:1]}; // RULE24
        if (ridx_q == 4'h9) begin
          rbusy_q <= 1'b0;
          rx_ev_q <= 1'b1;
          rx_ferr_q <= !rx_line; // RULE11
          rx_byte_q <= rshift_q;
        end
      end
    end
  end
  // ==========================================================
  // UART transmitter; driver enable follows the frame
  logic [15:0] tbit_q;
  logic [3:0] tidx_q;
  logic [9:0] tshift_q;
  logic tbusy_q;
  logic tx_start;
  logic [7:0] tx_byte;
  logic [7:0] last_sent_q;
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      tbit_q <= 16'h0000;
      tidx_q <= 4'h0;
      tshift_q <= 10'h3FF;
      tbusy_q <= 1'b0;
      last_sent_q <= 8'h00;
    end else if (clk_en) begin
      if (!attached) begin
        tbusy_q <= 1'b0;
        tshift_q <= 10'h3FF;
      end else if (tx_start) begin
        tbusy_q <= 1'b1;
        tshift_q <= {1'b1, tx_byte, 1'b0};
        tbit_q <= 16'(RSL_BIT_CYCLES - 1);
        tidx_q <= 4'h0;
        last_sent_q <= tx_byte;
      end else if (tbusy_q) begin
        if (tbit_q != 16'h0000) begin
          tbit_q <= tbit_q - 16'h0001;
        end else begin
          tbit_q <= 16'(RSL_BIT_CYCLES - 1);
          tshift_q <= {1'b1, tshift_q[9:1]};
          tidx_q <= tidx_q + 4'h1;
          if (tidx_q == 4'h9) tbusy_q <= 1'b0; // RULE17 RULE23: driver off at stop end
        end
      end
    end
  end
  // Pins are registered; the unselected link is never driven
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      tx_a <= 1'b1;
      tx_b <= 1'b1;
      tx_en_a <= 1'b0;
      tx_en_b <= 1'b0;
    end else if (clk_en) begin
      tx_a <= tshift_q[0];
      tx_b <= tshift_q[0];
      tx_en_a <= tbusy_q && attached && sel_a; // RULE1 RULE2
      tx_en_b <= tbusy_q && attached && sel_b; // RULE1 RULE2
    end
  end
  // ==========================================================
  // Slot-seeded pseudo-random source
  logic [15:0] lfsr_q;
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) lfsr_q <= 16'hACE1;
    else if (clk_en) lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]} ^ {8'h00, slot_addr}; // RULE28
  end
  // ==========================================================
  // Outgoing byte FIFO; stuffing happens on the way out
  logic [8:0] fifo_q_data;
  logic fifo_valid;
  logic fifo_pop;
  rsl_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_ok),
    .ce(clk_en),
    .in_data({send_last, send_data}),
    .in_valid(send_valid),
    .in_ready(send_ready),
    .out_data(fifo_q_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );
  // ==========================================================
  // Station state machine
  rsl_state_type st_q;
  logic [31:0] tmr_q;
  logic [3:0] arb_n_q;
  logic [3:0] tries_q;
  logic pend_esc_q;
  logic tx_wait_q;
  logic sent_close_q;
  logic rx_esc_q;
  logic rx_err_q;
  logic [10:0] rx_cnt_q;
  logic [15:0] rx_sum_q;
  logic [7:0] rx_dst_q;
  logic [7:0] rx_src_q;
  logic [15:0] rx_len_q;
  logic [7:0] rx_ch_q;
  logic back_to_arb_q;
  logic first_q;
  logic raw_ctl;
  logic is_ctrl;
  logic [7:0] rx_val;
  logic echo_bad;
  assign is_ctrl = fifo_q_data[7:0] >= RSL_UNUSED_BYTE; // RULE6 RULE7
  assign rx_val = rx_esc_q ? ~rx_byte_q : rx_byte_q; // RULE8
  assign echo_bad = rx_ev_q && (rx_ferr_q || rx_byte_q != last_sent_q); // RULE11
  assign tx_start = attached && !tbusy_q && !tx_wait_q && tmr_q == 32'h0 &&
    ((st_q == RSL_ST_ARB) || (st_q == RSL_ST_ABORT) || (st_q == RSL_ST_SEND && (fifo_valid || pend_esc_q)));
  // Framing bytes go raw: the first start byte and the close byte flagged last
  assign raw_ctl = (fifo_q_data[8] && fifo_q_data[7:0] == RSL_CLOSE_BYTE) ||
                   (first_q && fifo_q_data[7:0] == RSL_START_BYTE); // RULE21
  assign tx_byte = (st_q == RSL_ST_ARB) ? RSL_ARB_BYTE :
                   (st_q == RSL_ST_ABORT) ? RSL_ABORT_BYTE :
                   pend_esc_q ? ~fifo_q_data[7:0] :
                   (is_ctrl && !raw_ctl) ? RSL_INVERT_PREFIX : fifo_q_data[7:0]; // RULE7
  // Caller sends start byte raw (unstuffed first) and close byte flagged last
  assign fifo_pop = st_q == RSL_ST_SEND && tx_start && (pend_esc_q || !is_ctrl || raw_ctl);
  logic [31:0] rnd_slot;
  logic [31:0] rnd_back;
  assign rnd_slot = 32'(ARB_SLOT_CYC) * (32'(lfsr_q[2:0]) + 32'h1); // RULE18
  assign rnd_back = 32'(BACKOFF_MIN_CYC) + 32'(ARB_SLOT_CYC) * 32'(lfsr_q[4:0]); // RULE20
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      st_q <= RSL_ST_DETACHED;
      tmr_q <= 32'h0;
      arb_n_q <= 4'h0;
      tries_q <= 4'h0;
      pend_esc_q <= 1'b0;
      tx_wait_q <= 1'b0;
      back_to_arb_q <= 1'b0;
      first_q <= 1'b0;
      sent_close_q <= 1'b0;
      send_done <= 1'b0;
      send_failed <= 1'b0;
    end else if (clk_en) begin
      send_done <= 1'b0;
      send_failed <= 1'b0;
      if (tmr_q != 32'h0) tmr_q <= tmr_q - 32'h1;
      if (tx_start) tx_wait_q <= 1'b1;
      if (!attached) begin
        st_q <= RSL_ST_DETACHED; // RULE2
        tx_wait_q <= 1'b0;
        pend_esc_q <= 1'b0;
      end else case (st_q)
        RSL_ST_DETACHED: begin
          st_q <= RSL_ST_STARTUP;
          tmr_q <= 32'(STARTUP_CYC); // RULE13
        end
        RSL_ST_STARTUP: begin
          if (rx_ev_q && !rx_ferr_q) begin
            if (rx_byte_q == RSL_ARB_BYTE || rx_byte_q == RSL_CLOSE_BYTE || rx_byte_q == RSL_ABORT_BYTE)
              st_q <= RSL_ST_IDLE; // RULE13
            else begin
              st_q <= RSL_ST_RECEIVE; // RULE13
              tmr_q <= 32'(RECEIVE_CYC);
            end
          end else if (tmr_q == 32'h0) st_q <= RSL_ST_IDLE; // RULE13
        end
        RSL_ST_IDLE, RSL_ST_RECEIVE: begin
          if (rx_ev_q && !rx_ferr_q && rx_byte_q == RSL_START_BYTE) begin
            st_q <= RSL_ST_RECEIVE; // RULE14
            tmr_q <= 32'(RECEIVE_CYC);
          end else if (st_q == RSL_ST_RECEIVE && ((rx_ev_q && !rx_ferr_q && (rx_byte_q == RSL_CLOSE_BYTE ||
                       rx_byte_q == RSL_ABORT_BYTE || rx_byte_q == RSL_ARB_BYTE)) || tmr_q == 32'h0)) begin
            st_q <= RSL_ST_IDLE; // RULE14
          end else if (st_q == RSL_ST_IDLE && (fifo_valid || back_to_arb_q)) begin
            back_to_arb_q <= 1'b0;
            arb_n_q <= 4'h0;
            st_q <= (send_solicited || back_to_arb_q) ? RSL_ST_ARB : RSL_ST_BACKOFF; // RULE12
            tmr_q <= (send_solicited || back_to_arb_q) ? rnd_slot : rnd_back;
          end
        end
        RSL_ST_ARB: begin
          if (tx_wait_q && rx_ev_q) begin
            tx_wait_q <= 1'b0;
            if (echo_bad) begin
              st_q <= RSL_ST_BACKOFF; // RULE19
              tmr_q <= rnd_back;
            end else if (arb_n_q == 4'(RSL_ARB_COUNT - 1)) begin
              st_q <= RSL_ST_SEND; // RULE16
              first_q <= 1'b1;
              // Echo lands mid stop bit; one extra bit time keeps the idle gap long enough
              tmr_q <= 32'(RSL_GAP_CYC + RSL_BIT_CYCLES); // RULE26
            end else begin
              arb_n_q <= arb_n_q + 4'h1;
              tmr_q <= rnd_slot; // RULE18
            end
          end else if (!tx_wait_q && rx_ev_q) begin
            st_q <= RSL_ST_BACKOFF; // RULE19
            tmr_q <= rnd_back;
          end
        end
        RSL_ST_BACKOFF: begin
          if (rx_ev_q && !rx_ferr_q && rx_byte_q == RSL_START_BYTE) begin
            st_q <= RSL_ST_RECEIVE; // RULE19
            tmr_q <= 32'(RECEIVE_CYC);
            back_to_arb_q <= 1'b1;
          end else if (rx_ev_q) tmr_q <= rnd_back; // RULE19
          else if (tmr_q == 32'h0) begin
            st_q <= RSL_ST_ARB;
            arb_n_q <= 4'h0;
            tmr_q <= rnd_slot;
          end
        end
        RSL_ST_SEND: begin
          if (tx_start) begin
            pend_esc_q <= !pend_esc_q && tx_byte == RSL_INVERT_PREFIX; // RULE7
            sent_close_q <= fifo_pop && fifo_q_data[8];
            if (fifo_pop) first_q <= 1'b0;
          end
          if (tx_wait_q && rx_ev_q) begin
            tx_wait_q <= 1'b0;
            tmr_q <= 32'(RSL_GAP_CYC + RSL_BIT_CYCLES); // RULE22 RULE26
            if (echo_bad) begin
              st_q <= RSL_ST_ABORT; // RULE21
            end else if (sent_close_q) begin
              st_q <= RSL_ST_IDLE;
              tries_q <= 4'h0;
              send_done <= 1'b1;
            end
          end
        end
        RSL_ST_ABORT: begin
          if (tx_wait_q && rx_ev_q) begin
            tx_wait_q <= 1'b0;
            pend_esc_q <= 1'b0;
            if (tries_q == 4'(RSL_SEND_ATTEMPTS - 1)) begin
              st_q <= RSL_ST_IDLE; // RULE21
              tries_q <= 4'h0;
              send_failed <= 1'b1;
            end else begin
              tries_q <= tries_q + 4'h1;
              st_q <= RSL_ST_BACKOFF;
              tmr_q <= rnd_back;
            end
          end
        end
        default: st_q <= RSL_ST_DETACHED;
      endcase
    end
  end
  // ==========================================================
  // Receive path: unstuff, count, sum, validate on close
  always_ff @(posedge ref_clk or negedge rst_ok) begin
    if (!rst_ok) begin
      rx_esc_q <= 1'b0;
      rx_err_q <= 1'b0;
      rx_cnt_q <= 11'h000;
      rx_sum_q <= 16'h0000;
      rx_dst_q <= 8'h00;
      rx_src_q <= 8'h00;
      rx_len_q <= 16'h0000;
      rx_ch_q <= 8'h00;
      recv_data <= 8'h00;
      recv_valid <= 1'b0;
      recv_good <= 1'b0;
      recv_bad <= 1'b0;
    end else if (clk_en) begin
      recv_valid <= 1'b0;
      recv_good <= 1'b0;
      recv_bad <= 1'b0;
      if (rx_ev_q && st_q != RSL_ST_SEND && st_q != RSL_ST_ABORT && st_q != RSL_ST_ARB) begin
        if (rx_ferr_q) rx_err_q <= 1'b1; // RULE15
        else if (rx_byte_q == RSL_START_BYTE) begin
          rx_cnt_q <= 11'h000;
          rx_sum_q <= 16'h0000;
          rx_err_q <= 1'b0;
          rx_esc_q <= 1'b0;
        end else if (st_q == RSL_ST_RECEIVE && rx_byte_q == RSL_CLOSE_BYTE) begin
          // Checksum word replaces its two bytes in the sum; the close byte counts too
          if (!rx_err_q && rx_sum_q - 16'(rx_ch_q) - 16'(recv_data) + {rx_ch_q, recv_data} + 16'h00FF == 16'h0000 &&
              rx_src_q == RSL_MANAGER_ADDR && rx_dst_q == slot_addr && rx_cnt_q >= 11'h006 &&
              rx_len_q == 16'(rx_cnt_q) - 16'h0006) recv_good <= 1'b1; // RULE15 RULE25 RULE27
          else recv_bad <= 1'b1; // RULE15
        end else if (st_q == RSL_ST_RECEIVE && rx_byte_q == RSL_INVERT_PREFIX) rx_esc_q <= 1'b1; // RULE8
        else if (st_q == RSL_ST_RECEIVE && rx_byte_q < RSL_UNUSED_BYTE || rx_esc_q) begin
          rx_esc_q <= 1'b0;
          rx_cnt_q <= (rx_cnt_q == 11'h7FF) ? rx_cnt_q : rx_cnt_q + 11'h001;
          if (rx_cnt_q == 11'h000) rx_dst_q <= rx_val;
          if (rx_cnt_q == 11'h001) rx_src_q <= rx_val;
          if (rx_cnt_q == 11'h002) rx_len_q[15:8] <= rx_val;
          if (rx_cnt_q == 11'h003) rx_len_q[7:0] <= rx_val;
          // Byte before the newest; with recv_data it forms the checksum word
          rx_ch_q <= recv_data;
          rx_sum_q <= rx_sum_q + {8'h00, rx_val}; // RULE27
          recv_data <= rx_val;
          recv_valid <= 1'b1;
        end
      end
    end
  end
endmodule : rsl_station

// [verification/rsl_station_sva.sv]
// Checker for pin handling and pulse outputs of the station.
`timescale 1ns/1ns
module rsl_station_sva (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic select_a,
  input wire logic select_b,
  input wire logic link_isolate_a_n,
  input wire logic link_isolate_b_n,
  input wire logic controller_restart_a_n,
  input wire logic tx_en_a,
  input wire logic tx_en_b,
  input wire logic blade_controller_reset,
  input wire logic send_done,
  input wire logic send_failed,
  input wire logic recv_good,
  input wire logic recv_bad
);
  // ==========================================================
  // Pin patterns, held four cycles to cover the registered outputs
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence desel_s; select_a == select_b; endsequence
  sequence gate_a_s; select_a && !select_b && !link_isolate_a_n; endsequence
  sequence gate_b_s; select_b && !select_a && !link_isolate_b_n; endsequence
  sequence kill_a_s; select_a && !select_b && !link_isolate_a_n && !controller_restart_a_n; endsequence
  sequence calm_a_s; select_a && !select_b && link_isolate_a_n; endsequence
  sequence calm_b_s; select_b && !select_a && link_isolate_b_n; endsequence
  desel_off_a: assert property (desel_s [*4] |-> !(tx_en_a || tx_en_b)) else $error("driver on, deselected");
  one_link_a: assert property (!(tx_en_a && tx_en_b)) else $error("both drivers on");
  gate_a_a: assert property (gate_a_s [*4] |-> !tx_en_a) else $error("driver A on, isolated");
  gate_b_a: assert property (gate_b_s [*4] |-> !tx_en_b) else $error("driver B on, isolated");
  hold_ctl_a: assert property (kill_a_s [*4] |-> blade_controller_reset) else $error("no controller reset");
  restart_only_a: assert property (calm_a_s [*4] |-> !blade_controller_reset) else $error("stray reset A");
  other_pair_a: assert property (calm_b_s [*4] |-> !blade_controller_reset) else $error("stray reset B");
  // A send verdict pulse must fall the next cycle, and never both receive verdicts
  send_pulse_a: assert property ((send_done || send_failed) |=> !(send_done || send_failed)) else $error("send pulse");
  recv_once_a: assert property (!(recv_good && recv_bad)) else $error("two verdicts");
endmodule : rsl_station_sva
bind rsl_station rsl_station_sva u_sva (.ref_clk, .rst_n, .select_a, .select_b, .link_isolate_a_n,
  .link_isolate_b_n, .controller_restart_a_n, .tx_en_a, .tx_en_b, .blade_controller_reset, .send_done,
  .send_failed, .recv_good, .recv_bad);

// [verification/rsl_far_end.sv]
// Far-end bus model: echoes the station, sends frames, decodes what the station sends.
`timescale 1ns/1ns
module rsl_far_end (
  input wire logic clk,
  input wire logic tx,
  input wire logic tx_en,
  output logic rx
);
  import rsl_pkg::*;
  logic line_q = 1'b1;
  logic [7:0] seen[$];
  // ==========================================================
  // Bus wire; bias pulls an undriven line to idle high
  assign rx = tx_en ? tx : line_q;
  // Start bit, data LSB first, stop bit, then the minimum gap
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_q <= f[i];
      repeat (RSL_BIT_CYCLES) @(posedge clk);
    end
    repeat (RSL_GAP_CYC) @(posedge clk);
  endtask : put
  // Sample mid-bit; keep only bytes the station itself drove
  initial forever begin : decode
    logic [7:0] b;
    @(negedge tx);
    repeat (RSL_BIT_CYCLES * 3 / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      b[i] = tx;
      repeat (RSL_BIT_CYCLES) @(posedge clk);
    end
    if (tx_en) seen.push_back(b);
  end
endmodule : rsl_far_end

// [verification/tb_top.sv]
// Self-checking bench for the station link.
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb_top;
  import rsl_pkg::*;
  // ==========================================================
  // Signals
  logic ref_clk = 1'b0, rst_n = 1'b0, select_a = 1'b1, select_b = 1'b0;
  logic link_isolate_a_n = 1'b1, link_isolate_b_n = 1'b1, controller_restart_a_n = 1'b1, controller_restart_b_n = 1'b1;
  logic [7:0] slot_addr = 8'h01, send_data = 8'h00, recv_data;
  logic send_last = 1'b0, send_valid = 1'b0, send_solicited = 1'b1;
  logic rx_a, rx_b, tx_a, tx_b, tx_en_a, tx_en_b, blade_controller_reset;
  logic send_ready, send_done, send_failed, recv_valid, recv_good, recv_bad;
  logic [7:0] got[$], exp[$];
  logic [15:0] c;
  int n_errors = 0, cmp_count = 0, n_good = 0, n_bad = 0;
  // Short arbitration and startup counts keep the run brief
  rsl_station #(.STARTUP_CYC(500), .BACKOFF_MIN_CYC(100), .ARB_SLOT_CYC(100)) DUT (.ref_clk, .rst_n,
    .clk_en(1'b1), .slot_addr, .select_a, .select_b, .link_isolate_a_n, .link_isolate_b_n,
    .controller_restart_a_n, .controller_restart_b_n, .rx_a, .rx_b, .tx_a, .tx_b, .tx_en_a, .tx_en_b,
    .blade_controller_reset, .send_data, .send_last, .send_valid, .send_ready, .send_solicited,
    .send_done, .send_failed, .recv_data, .recv_valid, .recv_good, .recv_bad);
  rsl_far_end far_a (.clk(ref_clk), .tx(tx_a), .tx_en(tx_en_a), .rx(rx_a));
  rsl_far_end far_b (.clk(ref_clk), .tx(tx_b), .tx_en(tx_en_b), .rx(rx_b));
  always #20 ref_clk = ~ref_clk;
  // Collect inbound bytes and good verdicts
  always @(posedge ref_clk) begin
    if (recv_valid === 1'b1) got.push_back(recv_data);
    if (recv_good === 1'b1) n_good++;
    if (recv_bad === 1'b1 || send_failed === 1'b1) n_bad++;
  end
  // ==========================================================
  // Helpers
  function automatic logic [15:0] cks(input logic [7:0] s);
    return 16'h0000 - (16'h00E0 + 16'(s) + 16'h00FF);
  endfunction : cks
  // Valid stays up between calls so it never toggles twice in one step
  task automatic push(input logic [7:0] d, input logic l);
    int w;
    w = 0;
    send_data = d;
    send_last = l;
    send_valid = 1'b1;
    while (send_ready !== 1'b1 && w < 100000) begin
      @(posedge ref_clk);
      #2;
      w++;
    end
    @(posedge ref_clk);
    #2;
  endtask : push
  task automatic tally_and_finish();
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // Watchdog, roughly three times the expected run
  initial begin
    repeat (400000) @(posedge ref_clk);
    n_errors++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [5:0] p;
    int w;
    void'($urandom(91806));
    slot_addr = 8'($urandom_range(14, 1));
    c = cks(slot_addr);
    repeat (8) @(posedge ref_clk);
    #2 rst_n = 1'b1;
    // Corner pin patterns, random ones, then link A fully enabled
    for (int i = 0; i < 17; i++) begin
      p = (i == 0) ? 6'h01 : (i == 1) ? 6'h05 : (i == 2) ? 6'h02 : (i == 3) ? 6'h11 : (i == 16) ? 6'h3D : 6'($urandom);
      {controller_restart_b_n, controller_restart_a_n, link_isolate_b_n, link_isolate_a_n, select_b, select_a} = p;
      repeat (6) @(posedge ref_clk);
      #2;
      if (^p[1:0]) `CHK(blade_controller_reset, p[0] ? ~(p[2] | p[4]) : ~(p[3] | p[5]))
    end
    // Inbound packet; checksum high byte FE arrives escaped
    got.delete();
    exp = {RSL_START_BYTE, slot_addr, RSL_MANAGER_ADDR, 8'h00, 8'h00, RSL_INVERT_PREFIX, ~c[15:8], c[7:0], RSL_CLOSE_BYTE};
    foreach (exp[i]) far_a.put(exp[i]);
    repeat (20) @(posedge ref_clk);
    #2;
    exp = {slot_addr, RSL_MANAGER_ADDR, 8'h00, 8'h00, c[15:8], c[7:0]};
    foreach (exp[i]) `CHK(got[i], exp[i])
    `CHK(n_good, 1)
    // Outbound solicited packet, overfilling the FIFO while arbitrating
    exp = {RSL_START_BYTE, RSL_MANAGER_ADDR, slot_addr, 8'h00, 8'h00, c[15:8], c[7:0], RSL_CLOSE_BYTE};
    foreach (exp[i]) push(exp[i], i == 7);
    send_valid = 1'b0;
    w = 0;
    while (send_done !== 1'b1 && w < 300000) begin
      @(posedge ref_clk);
      #2;
      w++;
    end
    `CHK(send_done, 1'b1)
    repeat (500) @(posedge ref_clk);
    for (int i = 0; i < 8; i++) `CHK(far_a.seen[i], RSL_ARB_BYTE)
    exp = {RSL_START_BYTE, RSL_MANAGER_ADDR, slot_addr, 8'h00, 8'h00, RSL_INVERT_PREFIX, ~c[15:8], c[7:0], RSL_CLOSE_BYTE};
    foreach (exp[i]) `CHK(far_a.seen[i + 8], exp[i])
    `CHK(far_a.seen.size(), 17)
    `CHK(n_bad, 0)
    `CHK(far_b.seen.size(), 0)
    tally_and_finish();
  end
endmodule : tb_top
